/* design/acc_pkg.sv */
// Purpose: Shared constants and types for the converter control block.
// Assumes: One 200 MHz clock; registers reached over AXI4-Lite.
// Notes:   Register indices times four give the byte addresses.

// ****************************************************************
// Package
// ****************************************************************
package acc_pkg;

	// Bus geometry.
	localparam int          ADDR_W      = 12;
	localparam int          DATA_W      = 32;
	localparam int          IDX_W       = 10;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;

	// Register indices; the byte address is four times the index.
	localparam logic [IDX_W-1:0] RESULT_IDX     = 10'h070;
	localparam logic [IDX_W-1:0] CSR_IDX        = 10'h071;
	localparam logic [IDX_W-1:0] IRQ_STATUS_IDX = 10'h074;
	localparam logic [IDX_W-1:0] IRQ_CLEAR_IDX  = 10'h075;
	localparam logic [IDX_W-1:0] IRQ_ENABLE_IDX = 10'h076;
	localparam logic [IDX_W-1:0] MODE_IDX       = 10'h077;

	// Reset values.
	localparam logic [7:0] RESULT_RESET = 8'h00;
	localparam logic [7:0] CSR_RESET    = 8'h00;
	localparam logic [1:0] IRQ_RESET    = 2'h0;

	// Interrupt status bit positions.
	localparam int IRQ_OVERRUN_BIT = 0;
	localparam int IRQ_SETTLED_BIT = 1;
	localparam int IRQ_BITS        = 2;

	// Mode status bit positions.
	localparam int MODE_SETTLING_BIT = 0;
	localparam int MODE_BUSY_BIT     = 1;
	localparam int MODE_WAIT_BIT     = 2;

	// Conversion timing in converter clock ticks (one tick is two CPU clocks).
	localparam int         NUM_INPUTS_DEFAULT = 16;
	localparam logic [3:0] SAMPLE_TICKS       = 4'h3;
	localparam logic [3:0] SAR_STEPS          = 4'h8;
	localparam logic [7:0] TRIAL_MSB          = 8'h80;
	localparam logic [2:0] TOP_BIT            = 3'h7;

	// Stabilisation time after halt wakeup.
	localparam int         CLK_MHZ         = 200;
	localparam int         SETTLE_TIME_NS  = 1000;
	localparam int         SETTLE_CYC_INT  = (SETTLE_TIME_NS * CLK_MHZ + 999) / 1000;
	localparam logic [7:0] SETTLE_LAST     = 8'(SETTLE_CYC_INT - 1);

	// Control/status register layout.
	typedef struct packed {
		logic       done;
		logic       rsv6;
		logic       on;
		logic       rsv4;
		logic [3:0] channel_select;
	} acc_csr_s;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_SETTLE,
		ST_SAMPLE,
		ST_APPROX,
		ST_STORE
	} acc_state_e;

endpackage

/* design/acc_top.sv */
// Purpose: Control of an 8-bit successive-approximation converter.
// Assumes: Inputs synchronous to i_clock; comparator settles within one tick.
// Notes:   Completion never raises the interrupt line; only overrun and
//          settle-done events do.
//
// Added by the designer: the AXI4-Lite register port.

`timescale 1ns/1ps

// ****************************************************************
// Top module
// ****************************************************************
module acc_top #(
	parameter int NUM_INPUTS = acc_pkg::NUM_INPUTS_DEFAULT
) (
	// Clock and reset.
	input  wire logic                        i_clock,
	input  wire logic                        i_rst,
	// AXI4-Lite write address and data.
	input  wire logic                        i_awvalid,
	output logic                             o_awready,
	input  wire logic [acc_pkg::ADDR_W-1:0]  i_awaddr,
	input  wire logic [2:0]                  i_awprot,
	input  wire logic                        i_wvalid,
	output logic                             o_wready,
	input  wire logic [acc_pkg::DATA_W-1:0]  i_wdata,
	input  wire logic [3:0]                  i_wstrb,
	// AXI4-Lite write response.
	output logic                             o_bvalid,
	input  wire logic                        i_bready,
	output logic [1:0]                       o_bresp,
	// AXI4-Lite read.
	input  wire logic                        i_arvalid,
	output logic                             o_arready,
	input  wire logic [acc_pkg::ADDR_W-1:0]  i_araddr,
	input  wire logic [2:0]                  i_arprot,
	output logic                             o_rvalid,
	input  wire logic                        i_rready,
	output logic [acc_pkg::DATA_W-1:0]       o_rdata,
	output logic [1:0]                       o_rresp,
	// Low-power mode indications.
	input  wire logic                        i_wait_mode,
	input  wire logic                        i_halt_mode,
	// Analog front end.
	input  wire logic                        i_comp_above,
	output logic                             o_sample_en,
	output logic [7:0]                       o_trial_word,
	output logic [3:0]                       o_channel_select,
	output logic [NUM_INPUTS-1:0]            o_analog_input_sel,
	// Interrupt.
	output logic                             o_irq
);

	// ****************************************************************
	// Bus slave state
	// ****************************************************************
	logic                            aw_held, next_aw_held;
	logic                            w_held, next_w_held;
	logic [acc_pkg::IDX_W-1:0]       aw_idx, next_aw_idx;
	logic [7:0]                      w_byte, next_w_byte;
	logic                            w_lane0, next_w_lane0;
	logic                            bvalid, next_bvalid;
	logic [1:0]                      bresp, next_bresp;
	logic                            rvalid, next_rvalid;
	logic [acc_pkg::DATA_W-1:0]      rdata, next_rdata;
	logic [1:0]                      rresp, next_rresp;

	// Converter state.
	acc_pkg::acc_state_e             state, next_state;
	acc_pkg::acc_csr_s               control_status_reg, next_csr;
	logic [7:0]                      result, next_result;
	logic [7:0]                      trial, next_trial;
	logic [3:0]                      tick_cnt, next_tick_cnt;
	logic [7:0]                      settle_cnt, next_settle_cnt;
	logic                            div, next_div;
	logic                            halt_q, next_halt_q;
	logic                            wait_q, next_wait_q;
	logic                            sample_en, next_sample_en;
	logic [acc_pkg::IRQ_BITS-1:0]    irq_status, next_irq_status;
	logic [acc_pkg::IRQ_BITS-1:0]    irq_enable, next_irq_enable;
	logic                            irq, next_irq;
	logic [NUM_INPUTS-1:0]           in_sel, next_in_sel;

	// Handshake pulses seen by the converter group.
	logic                            wr_do;
	logic                            ar_do;
	logic                            wr_ok;
	logic [acc_pkg::IDX_W-1:0]       ar_idx;

	assign wr_do  = aw_held & w_held & ~bvalid;
	assign wr_ok  = wr_do & w_lane0;
	// A read is taken only while ready is shown, so none slips in just after reset.
	assign ar_do  = i_arvalid & o_arready;
	assign ar_idx = i_araddr[acc_pkg::ADDR_W-1:2];

	// ****************************************************************
	// AXI4-Lite slave
	// ****************************************************************

	// Address and data are held separately so either may arrive first.
	always_comb begin
		next_aw_held = aw_held;
		next_w_held  = w_held;
		next_aw_idx  = aw_idx;
		next_w_byte  = w_byte;
		next_w_lane0 = w_lane0;
		next_bvalid  = bvalid;
		next_bresp   = bresp;
		next_rvalid  = rvalid;
		next_rdata   = rdata;
		next_rresp   = rresp;
		if (i_awvalid && o_awready) begin
			next_aw_held = 1'b1;
			next_aw_idx  = i_awaddr[acc_pkg::ADDR_W-1:2];
		end
		if (i_wvalid && o_wready) begin
			next_w_held  = 1'b1;
			next_w_byte  = i_wdata[7:0];
			next_w_lane0 = i_wstrb[0];
		end
		if (bvalid && i_bready) begin
			next_bvalid = 1'b0;
		end
		if (wr_do) begin
			next_aw_held = 1'b0;
			next_w_held  = 1'b0;
			next_bvalid  = 1'b1;
			unique case (aw_idx)
				acc_pkg::CSR_IDX, acc_pkg::IRQ_CLEAR_IDX,
				acc_pkg::IRQ_ENABLE_IDX: next_bresp = acc_pkg::RESP_OKAY;
				default:                 next_bresp = acc_pkg::RESP_SLVERR;
			endcase
		end
		if (rvalid && i_rready) begin
			next_rvalid = 1'b0;
		end
		if (ar_do) begin
			next_rvalid = 1'b1;
			next_rresp  = acc_pkg::RESP_OKAY;
			next_rdata  = '0;
			unique case (ar_idx)
				acc_pkg::RESULT_IDX:     next_rdata[7:0] = result;
				acc_pkg::CSR_IDX:        next_rdata[7:0] = control_status_reg;
				acc_pkg::IRQ_STATUS_IDX: next_rdata[acc_pkg::IRQ_BITS-1:0] = irq_status;
				acc_pkg::IRQ_ENABLE_IDX: next_rdata[acc_pkg::IRQ_BITS-1:0] = irq_enable;
				acc_pkg::IRQ_CLEAR_IDX:  next_rdata = '0;
				acc_pkg::MODE_IDX: begin
					next_rdata[acc_pkg::MODE_SETTLING_BIT] = (state == acc_pkg::ST_SETTLE);
					next_rdata[acc_pkg::MODE_BUSY_BIT]     = (state != acc_pkg::ST_OFF);
					next_rdata[acc_pkg::MODE_WAIT_BIT]     = wait_q;
				end
				default:                 next_rresp = acc_pkg::RESP_SLVERR;
			endcase
		end
	end

	// Bus registers; ready outputs reflect the free holding slots.
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			aw_held   <= 1'b0;
			w_held    <= 1'b0;
			aw_idx    <= '0;
			w_byte    <= 8'h00;
			w_lane0   <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= acc_pkg::RESP_OKAY;
			rvalid    <= 1'b0;
			rdata     <= '0;
			rresp     <= acc_pkg::RESP_OKAY;
			o_awready <= 1'b0;
			o_wready  <= 1'b0;
			o_arready <= 1'b0;
		end else begin
			aw_held   <= next_aw_held;
			w_held    <= next_w_held;
			aw_idx    <= next_aw_idx;
			w_byte    <= next_w_byte;
			w_lane0   <= next_w_lane0;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
			o_awready <= ~next_aw_held;
			o_wready  <= ~next_w_held;
			o_arready <= ~next_rvalid;
		end
	end

	assign o_bvalid = bvalid;
	assign o_bresp  = bresp;
	assign o_rvalid = rvalid;
	assign o_rdata  = rdata;
	assign o_rresp  = rresp;

	// ****************************************************************
	// Converter sequencer and registers
	// ****************************************************************

	// Priority: halt, then a CONTROL_STATUS_REG write, then the running sequence.
	always_comb begin
		logic       tick;
		logic       clr_done;
		logic       set_done;
		logic [2:0] bit_pos;
		tick            = div;
		clr_done        = 1'b0;
		set_done        = 1'b0;
		bit_pos         = acc_pkg::TOP_BIT - tick_cnt[2:0];
		next_state      = state;
		next_csr        = control_status_reg;
		next_result     = result;
		next_trial      = trial;
		next_tick_cnt   = tick_cnt;
		next_settle_cnt = settle_cnt;
		next_div        = ~div;
		next_halt_q     = i_halt_mode;
		next_wait_q     = i_wait_mode;
		next_irq_status = irq_status;
		next_irq_enable = irq_enable;

		unique case (state)
			acc_pkg::ST_OFF: begin
			end
			acc_pkg::ST_SETTLE: begin
				next_settle_cnt = settle_cnt + 8'h01;
				if (settle_cnt == acc_pkg::SETTLE_LAST) begin
					next_state    = acc_pkg::ST_SAMPLE;
					next_tick_cnt = 4'h0;
					next_div      = 1'b0;
					next_irq_status[acc_pkg::IRQ_SETTLED_BIT] = 1'b1;
				end
			end
			acc_pkg::ST_SAMPLE: if (tick) begin
				next_tick_cnt = tick_cnt + 4'h1;
				if (tick_cnt == acc_pkg::SAMPLE_TICKS - 4'h1) begin
					next_state    = acc_pkg::ST_APPROX;
					next_tick_cnt = 4'h0;
					next_trial    = acc_pkg::TRIAL_MSB;
				end
			end
			acc_pkg::ST_APPROX: if (tick) begin
				next_trial[bit_pos] = i_comp_above;
				if (bit_pos != 3'h0) begin
					next_trial[bit_pos - 3'h1] = 1'b1;
				end
				next_tick_cnt = tick_cnt + 4'h1;
				if (tick_cnt == acc_pkg::SAR_STEPS - 4'h1) begin
					next_state = acc_pkg::ST_STORE;
				end
			end
			acc_pkg::ST_STORE: if (tick) begin
				next_result = trial;
				set_done    = 1'b1;
				if (control_status_reg.done) begin
					next_irq_status[acc_pkg::IRQ_OVERRUN_BIT] = 1'b1;
				end
				next_state    = acc_pkg::ST_SAMPLE;
				next_tick_cnt = 4'h0;
				next_trial    = 8'h00;
			end
		endcase

		if (ar_do && ar_idx == acc_pkg::RESULT_IDX) begin
			clr_done = 1'b1;
		end
		if (wr_ok && aw_idx == acc_pkg::IRQ_ENABLE_IDX) begin
			next_irq_enable = w_byte[acc_pkg::IRQ_BITS-1:0];
		end
		if (wr_ok && aw_idx == acc_pkg::IRQ_CLEAR_IDX) begin
			next_irq_status = next_irq_status & ~w_byte[acc_pkg::IRQ_BITS-1:0];
			if (state == acc_pkg::ST_SETTLE && settle_cnt == acc_pkg::SETTLE_LAST) begin
				next_irq_status[acc_pkg::IRQ_SETTLED_BIT] = 1'b1;
			end
			if (state == acc_pkg::ST_STORE && tick && control_status_reg.done) begin
				next_irq_status[acc_pkg::IRQ_OVERRUN_BIT] = 1'b1;
			end
		end
		if (wr_ok && aw_idx == acc_pkg::CSR_IDX) begin
			next_csr.on             = w_byte[5];
			next_csr.channel_select = w_byte[3:0];
			clr_done                = 1'b1;
			if (!w_byte[5]) begin
				next_state = acc_pkg::ST_OFF;
			end else if (state != acc_pkg::ST_SETTLE && !i_halt_mode) begin
				next_state    = acc_pkg::ST_SAMPLE;
				next_tick_cnt = 4'h0;
				next_trial    = 8'h00;
				next_div      = 1'b0;
				set_done      = 1'b0;
				next_result   = result;
			end
		end

		if (i_halt_mode) begin
			next_state = acc_pkg::ST_OFF;
			set_done   = 1'b0;
		end else if (halt_q && next_csr.on) begin
			next_state      = acc_pkg::ST_SETTLE;
			next_settle_cnt = 8'h00;
		end

		next_csr.done = (control_status_reg.done & ~clr_done) | set_done;
		next_csr.rsv6 = 1'b0;
		next_csr.rsv4 = 1'b0;
		next_sample_en = (next_state == acc_pkg::ST_SAMPLE);
		next_irq       = |(next_irq_status & next_irq_enable);
	end

	// one select line per implemented input.
	generate
		for (genvar g = 0; g < NUM_INPUTS; g++) begin : g_sel
			assign next_in_sel[g] = (next_csr.channel_select == 4'(g));
		end
	endgenerate

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state      <= acc_pkg::ST_OFF;
			control_status_reg        <= acc_pkg::CSR_RESET;
			result     <= acc_pkg::RESULT_RESET;
			trial      <= 8'h00;
			tick_cnt   <= 4'h0;
			settle_cnt <= 8'h00;
			div        <= 1'b0;
			halt_q     <= 1'b0;
			wait_q     <= 1'b0;
			sample_en  <= 1'b0;
			irq_status <= acc_pkg::IRQ_RESET;
			irq_enable <= acc_pkg::IRQ_RESET;
			irq        <= 1'b0;
			in_sel     <= '0;
		end else begin
			state      <= next_state;
			control_status_reg        <= next_csr;
			result     <= next_result;
			trial      <= next_trial;
			tick_cnt   <= next_tick_cnt;
			settle_cnt <= next_settle_cnt;
			div        <= next_div;
			halt_q     <= next_halt_q;
			wait_q     <= next_wait_q;
			sample_en  <= next_sample_en;
			irq_status <= next_irq_status;
			irq_enable <= next_irq_enable;
			irq        <= next_irq;
			in_sel     <= next_in_sel;
		end
	end

	// Analog side sees only registered values to avoid glitches on the mux.
	assign o_sample_en        = sample_en;
	assign o_trial_word       = trial;
	assign o_channel_select   = control_status_reg.channel_select;
	assign o_analog_input_sel = in_sel;
	assign o_irq              = irq;

endmodule

/* dv/acc_props.sv */
// Purpose: Port-level assertions for the converter control block.
// Assumes: One clock domain with a synchronous active-high reset.
// Notes:   Timing checks skip windows disturbed by bus writes or halt.

`timescale 1ns/1ps

// ****************************************************************
// Checker
// ****************************************************************
module acc_props #(
	parameter int NUM_INPUTS = 16
) (
	// Clock and reset.
	input logic                       i_clock,
	input logic                       i_rst,
	// Bus handshake.
	input logic                       i_awvalid,
	input logic                       o_awready,
	input logic                       o_wready,
	input logic                       o_bvalid,
	input logic [1:0]                 o_bresp,
	input logic                       o_arready,
	input logic                       o_rvalid,
	input logic                       i_rready,
	input logic [acc_pkg::DATA_W-1:0] o_rdata,
	// Converter and interrupt.
	input logic                       i_halt_mode,
	input logic                       o_sample_en,
	input logic [3:0]                 o_channel_select,
	input logic [NUM_INPUTS-1:0]      o_analog_input_sel,
	input logic                       o_irq
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_rst);

	logic [5:0] quiet;
	logic [5:0] hi;
	logic [5:0] lo;
	logic [5:0] next_quiet;
	logic [5:0] next_hi;
	logic [5:0] next_lo;

	// Calm-cycle and level-run counters; a write or halt may legally cut a conversion short.
	always_comb begin
		next_quiet = (i_halt_mode || (i_awvalid && o_awready)) ? 6'h0 : quiet + 6'(quiet != 6'h3f);
		next_hi = o_sample_en ? hi + 6'(hi != 6'h3f) : 6'h0;
		next_lo = o_sample_en ? 6'h0 : lo + 6'(lo != 6'h3f);
		if (i_rst) begin
			next_quiet = 6'h0;
			next_hi = 6'h0;
			next_lo = 6'h0;
		end
	end

	// Register the counters.
	always_ff @(posedge i_clock) begin
		quiet <= next_quiet;
		hi <= next_hi;
		lo <= next_lo;
	end

	property p_ready_after_reset;
		$fell(i_rst) |=> o_awready && o_wready && o_arready;
	endproperty
	property p_refused;
		o_rvalid |-> !o_arready;
	endproperty
	property p_rvalid_drop;
		o_rvalid && i_rready |=> !o_rvalid;
	endproperty
	property p_bvalid_take;
		$rose(o_bvalid) |-> !$past(o_awready) && !$past(o_wready);
	endproperty
	property p_rdata_upper;
		o_rvalid |-> o_rdata[31:8] == 24'h0;
	endproperty
	property p_halt_stops;
		i_halt_mode |-> ##2 !o_sample_en;
	endproperty
	property p_sample_len;
		$fell(o_sample_en) && quiet >= 6'd12 |-> hi == 6'd6;
	endproperty
	property p_period;
		$rose(o_sample_en) && quiet >= 6'd40 && lo < 6'd40 |-> lo == 6'd18;
	endproperty
	property p_input_sel;
		$stable(o_channel_select) && !$past(i_rst) && !$past(i_rst, 2) |->
			o_analog_input_sel == ((o_channel_select < NUM_INPUTS) ?
			NUM_INPUTS'(1) << o_channel_select : '0);
	endproperty

	a_ready_after_reset: assert property (p_ready_after_reset) else $error("Readies low.");
	a_refused: assert property (p_refused) else $error("Read taken while busy.");
	a_rvalid_drop: assert property (p_rvalid_drop) else $error("Read answer stuck.");
	a_bvalid_take: assert property (p_bvalid_take) else $error("Early write answer.");
	a_rdata_upper: assert property (p_rdata_upper) else $error("Upper bits set.");
	a_halt_stops: assert property (p_halt_stops) else $error("Sampling in halt.");
	a_sample_len: assert property (p_sample_len) else $error("Bad sample length.");
	a_period: assert property (p_period) else $error("Bad conversion period.");
	a_input_sel: assert property (p_input_sel) else $error("Bad input select.");

	c_sample: cover property ($rose(o_sample_en));
	c_irq: cover property ($rose(o_irq));
	c_err: cover property (o_bvalid && o_bresp == acc_pkg::RESP_SLVERR);
endmodule

bind acc_top acc_props #(.NUM_INPUTS(NUM_INPUTS)) u_props (.i_clock, .i_rst, .i_awvalid,
	.o_awready, .o_wready, .o_bvalid, .o_bresp, .o_arready, .o_rvalid, .i_rready, .o_rdata,
	.i_halt_mode, .o_sample_en, .o_channel_select, .o_analog_input_sel, .o_irq);

/* dv/acc_front_model.sv */
// Purpose: Behavioural comparator and input levels facing the converter.
// Assumes: Analog input n holds the level {n, ~n}.
// Notes:   The decision is junk while sampling, as on a real comparator.

`timescale 1ns/1ps

// ****************************************************************
// Front-end model
// ****************************************************************
module acc_front_model (
	// Clock.
	input  logic       i_clock,
	// Converter side.
	input  logic       i_sample_en,
	input  logic [3:0] i_channel_select,
	input  logic [7:0] i_trial_word,
	// Comparator decision.
	output logic       o_comp_above
);
	logic junk = 1'b0;

	// Toggle so a decision taken during sampling cannot pass by luck.
	always @(posedge i_clock) junk <= ~junk;

	assign o_comp_above = i_sample_en ? junk :
		({i_channel_select, ~i_channel_select} >= i_trial_word);
endmodule

/* dv/acc_top_tb.sv */
// Purpose: Self-checking bench for the converter control block.
// Assumes: Front-end model gives input n the level {n, ~n}.
// Notes:   Twelve inputs are built so the upper channel codes select none.

`timescale 1ns/1ps

// ****************************************************************
// Bench
// ****************************************************************
module acc_top_tb;
	localparam int         N_IN = 12;
	localparam logic [9:0] CTL  = acc_pkg::CSR_IDX;
	localparam logic [9:0] RES  = acc_pkg::RESULT_IDX;
	localparam logic [9:0] IST  = acc_pkg::IRQ_STATUS_IDX;
	localparam logic [9:0] ICL  = acc_pkg::IRQ_CLEAR_IDX;
	localparam logic [9:0] IEN  = acc_pkg::IRQ_ENABLE_IDX;
	localparam logic [9:0] MDE  = acc_pkg::MODE_IDX;
	localparam logic [1:0] OK   = acc_pkg::RESP_OKAY;
	localparam logic [1:0] ERR  = acc_pkg::RESP_SLVERR;
	typedef struct packed {
		logic        wr;
		logic [9:0]  idx;
		logic [31:0] d;
		logic [31:0] x;
		logic [1:0]  r;
	} acc_row_s;
	// Rows: write flag, place, data, expected data, expected response.
	acc_row_s rows [9] = '{
		'{1'b1, CTL, 32'h0f, 32'h0, OK},
		'{1'b0, CTL, 32'h0, 32'h0f, OK},
		'{1'b1, RES, 32'h55, 32'h0, ERR},
		'{1'b0, RES, 32'h0, 32'h0, OK},
		'{1'b1, 10'h3ff, 32'h1, 32'h0, ERR},
		'{1'b1, IEN, 32'h3, 32'h0, OK},
		'{1'b0, IEN, 32'h0, 32'h3, OK},
		'{1'b0, ICL, 32'h0, 32'h0, OK},
		'{1'b1, MDE, 32'h1, 32'h0, ERR}
	};
	logic [9:0]      zidx [4] = '{CTL, RES, IEN, IST};
	logic [3:0]      chs [2] = '{4'h3, 4'hb};
	logic            i_clock, i_rst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
	logic            i_wait_mode, i_halt_mode, comp;
	logic [11:0]     i_awaddr, i_araddr;
	logic [31:0]     i_wdata, o_rdata, d;
	logic [3:0]      i_wstrb, o_channel_select;
	logic [2:0]      i_awprot = 3'h0, i_arprot = 3'h0;
	logic            o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sample_en, o_irq;
	logic [1:0]      o_bresp, o_rresp, r;
	logic [7:0]      o_trial_word;
	logic [N_IN-1:0] o_analog_input_sel;
	int              mismatches = 0, check_count = 0, n, k, hits;

	acc_top #(.NUM_INPUTS(N_IN)) uut (.i_clock, .i_rst, .i_awvalid, .o_awready, .i_awaddr,
		.i_awprot, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp,
		.i_arvalid, .o_arready, .i_araddr, .i_arprot, .o_rvalid, .i_rready, .o_rdata, .o_rresp,
		.i_wait_mode, .i_halt_mode, .i_comp_above(comp), .o_sample_en, .o_trial_word,
		.o_channel_select, .o_analog_input_sel, .o_irq);
	acc_front_model u_front (.i_clock, .i_sample_en(o_sample_en),
		.i_channel_select(o_channel_select), .i_trial_word(o_trial_word), .o_comp_above(comp));

	// Verdict and end of run.
	task automatic stop_test;
		if (mismatches == 0 && check_count > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	// A wait that ran out counts as a mismatch.
	task automatic lost;
		mismatches++;
		stop_test();
	endtask
	// Compare one value.
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bus write; address and data are released each when taken.
	task automatic wr(input logic [9:0] idx, input logic [31:0] dat, output logic [1:0] rsp);
		@(posedge i_clock);
		i_awvalid <= 1'b1;
		i_awaddr <= {idx, 2'h0};
		i_wvalid <= 1'b1;
		i_wdata <= dat;
		i_bready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clock);
			if (i_awvalid && o_awready === 1'b1) i_awvalid <= 1'b0;
			if (i_wvalid && o_wready === 1'b1) i_wvalid <= 1'b0;
			if (o_bvalid === 1'b1) break;
		end
		if (n == 100) lost();
		rsp = o_bresp;
		i_bready <= 1'b0;
	endtask
	// Bus read.
	task automatic rd(input logic [9:0] idx, output logic [31:0] dat, output logic [1:0] rsp);
		@(posedge i_clock);
		i_arvalid <= 1'b1;
		i_araddr <= {idx, 2'h0};
		i_rready <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clock);
			if (i_arvalid && o_arready === 1'b1) i_arvalid <= 1'b0;
			if (o_rvalid === 1'b1) break;
		end
		if (n == 100) lost();
		dat = o_rdata;
		rsp = o_rresp;
		i_rready <= 1'b0;
	endtask
	// Poll the done flag under a bound.
	task automatic poll;
		logic [31:0] v;
		logic [1:0]  s;
		for (k = 0; k < 40; k++) begin
			rd(CTL, v, s);
			if (v[7] === 1'b1) break;
		end
		if (k == 40) lost();
	endtask

	// Free-running 200 MHz clock.
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end

	// Main sequence.
	initial begin
		{i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_wait_mode, i_halt_mode} = '0;
		{i_awaddr, i_araddr, i_wdata} = '0;
		i_wstrb = 4'h1;
		i_rst = 1'b1;
		repeat (6) @(posedge i_clock);
		i_rst <= 1'b0;
		foreach (rows[q]) begin
			if (rows[q].wr) begin
				wr(rows[q].idx, rows[q].d, r);
			end else begin
				rd(rows[q].idx, d, r);
				chk(d, rows[q].x);
			end
			chk(32'(r), 32'(rows[q].r));
		end
		for (k = 0; k < 16; k++) begin
			wr(CTL, 32'(k), r);
			repeat (2) @(posedge i_clock);
			chk(32'(o_channel_select), 32'(k));
			chk(32'(o_analog_input_sel), (k < N_IN) ? 32'h1 << k : 32'h0);
		end
		foreach (chs[j]) begin
			i_wait_mode <= j[0];
			wr(CTL, 32'h20 | 32'(chs[j]), r);
			poll();
			wr(CTL, 32'h20 | 32'(chs[j]), r);
			rd(CTL, d, r);
			chk(d, 32'h20 | 32'(chs[j]));
			rd(MDE, d, r);
			chk(d, 32'h2 | (32'(j) << 2));
			poll();
			rd(RES, d, r);
			chk(d, 32'({chs[j], ~chs[j]}));
			rd(CTL, d, r);
			chk(d, 32'h20 | 32'(chs[j]));
		end
		i_wait_mode <= 1'b0;
		wr(CTL, 32'h03, r);
		repeat (2) @(posedge i_clock);
		hits = 0;
		repeat (80) @(posedge i_clock) hits += int'(o_sample_en !== 1'b0);
		chk(32'(hits), 32'h0);
		wr(ICL, 32'h3, r);
		wr(CTL, 32'h23, r);
		repeat (30) @(posedge i_clock);
		i_halt_mode <= 1'b1;
		repeat (20) @(posedge i_clock);
		chk(32'(o_sample_en), 32'h0);
		i_halt_mode <= 1'b0;
		for (n = 0; n < 400; n++) begin
			@(posedge i_clock);
			if (o_sample_en === 1'b1) break;
		end
		if (n == 400) lost();
		chk(32'(n >= 190 && n < 400), 32'h1);
		chk(32'(o_irq), 32'h1);
		rd(IST, d, r);
		chk(d & 32'h2, 32'h2);
		wr(ICL, 32'h3, r);
		wr(IEN, 32'h2, r);
		repeat (2) @(posedge i_clock);
		hits = 0;
		repeat (80) @(posedge i_clock) hits += int'(o_irq !== 1'b0);
		chk(32'(hits), 32'h0);
		wr(IEN, 32'h1, r);
		repeat (2) @(posedge i_clock);
		chk(32'(o_irq), 32'h1);
		wr(IEN, 32'h0, r);
		repeat (2) @(posedge i_clock);
		chk(32'(o_irq), 32'h0);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		foreach (zidx[q]) begin
			rd(zidx[q], d, r);
			chk(d, 32'h0);
		end
		stop_test();
	end
endmodule
